//--- src/sabm_aps_monitor.sv
// Purpose: APS K1/K2 monitor for a protected pair of line ports, with APB status.
// Assumes: K bytes, frame strobe and per-port fail/degrade come from the framer on clk.
// Notes:   Port 0 is the working port; port 1 is the protection port.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "sabm_cfg.svh"

// What this block does
// - Flag K2 architecture or mode differing from local.
// - Flag received K2 channel differing from sent.
// - Inconsistent if 12 frames lack three identical.
// - Invalid if bad request code three frames.
// - Invalid if bad channel three frames.
// - Switch byte failure while inconsistent or invalid.
// - Far-end fault on signal fail for protection.
// - Show and count signal fail per port.
// - Show and count signal degrade per port.
// - Report primary or secondary for each port.
// - Lockout blocks switching to secondary; report it.
// - Report switch status after traffic moved.
// - Report wait-to-restore while it is timed.
// - Confirmed clear zeroes every APS counter.
// - Decode K1 request bits to known codes.
// - K1 low nibble is the request channel.
module sabm_aps_monitor
	import sabm_pkg::*;
#(
	parameter logic [15:0] WTR_FRAMES = `SABM_WTR_FRAMES
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        frameStb,
	input  wire sabm_rx_s    rxBytes,
	input  wire logic [1:0]  signalFail,
	input  wire logic [1:0]  signalDegrade
);
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        nxt_pslverr;
	sabm_ctrl_s  ctrl_ff;
	sabm_ctrl_s  nxt_ctrl;
	logic        wrHit;
	logic        clrHit;
	logic [7:0]  hist_ff [`SABM_HIST_LEN];
	logic [7:0]  nxt_hist [`SABM_HIST_LEN];
	logic [3:0]  histFill_ff;
	logic [3:0]  nxt_histFill;
	logic [`SABM_HIST_LEN-3:0] run3;
	logic [1:0]  badRun_ff;
	logic [1:0]  nxt_badRun;
	logic        badFrame;
	logic [15:0] validReq;
	logic        incons_ff;
	logic        nxt_incons;
	logic        invalid_ff;
	logic        nxt_invalid;
	logic        modeMis_ff;
	logic        nxt_modeMis;
	logic        chanMis_ff;
	logic        nxt_chanMis;
	logic        farEndProtectLineFault_ff;
	logic        nxt_farEndProtectLineFault;
	logic        swByteFail;
	sabm_rx_s    rxLast_ff;
	sabm_rx_s    nxt_rxLast;
	logic [`SABM_NUM_CNT-1:0] cond;
	logic [`SABM_NUM_CNT-1:0] condPrev_ff;
	logic [`SABM_NUM_CNT-1:0] onset;
	logic [31:0] cnt_ff [`SABM_NUM_CNT];
	logic [31:0] nxt_cnt [`SABM_NUM_CNT];
	sabm_prot_e  state_ff;
	sabm_prot_e  nxt_state;
	logic [15:0] wtrCnt_ff;
	logic [15:0] nxt_wtrCnt;
	logic [31:0] statWord;
	logic [2:0]  cntIdx;

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign wrHit   = psel && penable && pready_ff && pwrite;
	assign clrHit  = wrHit && (paddr == `SABM_ADDR_CLEAR) && (pwdata == `SABM_CLR_KEY);
	assign cntIdx  = 3'((paddr - `SABM_ADDR_CNT_LO) >> 2);

	// A bad request code or channel each counts toward the invalid-code run.
	assign validReq = `SABM_VALID_REQ;
	assign badFrame = !validReq[rxBytes.k1[7:4]]
		|| (rxBytes.k1[3:0] > `SABM_MAX_CHAN);

	assign swByteFail = incons_ff || invalid_ff;
	assign cond       = {signalDegrade, signalFail, farEndProtectLineFault_ff, swByteFail,
		chanMis_ff, modeMis_ff};
	assign onset      = cond & ~condPrev_ff;

	// Port 1 carries traffic in every state but NORMAL; bit 6 says which port is primary.
	assign statWord = {18'h0, signalDegrade, signalFail, ctrl_ff.lockout,
		state_ff == PS_WTR, state_ff == PS_SWITCHED,
		state_ff != PS_NORMAL,
		invalid_ff, incons_ff, farEndProtectLineFault_ff, swByteFail, chanMis_ff, modeMis_ff};

	always_comb
	begin
		nxt_prdata  = prdata_ff;
		nxt_pslverr = pslverr_ff;
		nxt_ctrl    = ctrl_ff;
		if (psel && !penable)
		begin
			nxt_prdata  = 32'h0;
			nxt_pslverr = 1'b0;
			if (paddr[1:0] != 2'h0)
				nxt_pslverr = 1'b1;
			else if (paddr == `SABM_ADDR_CTRL)
				nxt_prdata = {23'h0, ctrl_ff};
			else if (paddr == `SABM_ADDR_STAT)
				nxt_prdata = statWord;
			else if (paddr == `SABM_ADDR_RXK)
				nxt_prdata = {16'h0, rxLast_ff};
			else if (paddr >= `SABM_ADDR_CNT_LO && paddr <= `SABM_ADDR_CNT_HI)
				nxt_prdata = cnt_ff[cntIdx];
			else if (paddr != `SABM_ADDR_CLEAR)
				nxt_pslverr = 1'b1;
		end
		if (wrHit && paddr == `SABM_ADDR_CTRL)
			nxt_ctrl = sabm_ctrl_s'(pwdata[8:0]);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prdata_ff  <= 32'h0;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			ctrl_ff    <= sabm_ctrl_s'(`SABM_CTRL_RST);
		end
		else
		begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= psel && !penable;
			pslverr_ff <= nxt_pslverr;
			ctrl_ff    <= nxt_ctrl;
		end
	end

	// A run of three needs three neighbours, so the check only counts once history is full.
	genvar gi;
	generate
		for (gi = 0; gi < `SABM_HIST_LEN - 2; gi++)
		begin : g_run
			assign run3[gi] = (hist_ff[gi] == hist_ff[gi+1]) && (hist_ff[gi+1] == hist_ff[gi+2]);
		end
	endgenerate

	always_comb
	begin
		nxt_hist     = hist_ff;
		nxt_histFill = histFill_ff;
		nxt_badRun   = badRun_ff;
		nxt_invalid  = invalid_ff;
		nxt_modeMis  = modeMis_ff;
		nxt_chanMis  = chanMis_ff;
		nxt_rxLast   = rxLast_ff;
		nxt_farEndProtectLineFault = farEndProtectLineFault_ff;
		nxt_incons   = (histFill_ff == `SABM_HIST_FULL) && !(|run3);
		if (frameStb)
		begin
			nxt_rxLast = rxBytes;
			nxt_hist[0] = rxBytes.k1;
			for (int i = 1; i < `SABM_HIST_LEN; i++)
				nxt_hist[i] = hist_ff[i-1];
			if (histFill_ff != `SABM_HIST_FULL)
				nxt_histFill = histFill_ff + 4'h1;
			nxt_badRun  = !badFrame ? 2'h0 :
				(badRun_ff == `SABM_RUN_MAX) ? badRun_ff : badRun_ff + 2'h1;
			nxt_invalid = badFrame && (badRun_ff >= `SABM_RUN_DECLARE);
			nxt_modeMis = (rxBytes.k2[3] != ctrl_ff.arch)
				|| (rxBytes.k2[2:0] != ctrl_ff.mode);
			nxt_chanMis = rxBytes.k2[7:4] != ctrl_ff.txChan;
			nxt_farEndProtectLineFault = ((rxBytes.k1[7:4] == `SABM_REQ_SF_LO)
				|| (rxBytes.k1[7:4] == `SABM_REQ_SF_HI))
				&& (rxBytes.k1[3:0] == `SABM_PROT_CHAN);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `SABM_HIST_LEN; i++)
				hist_ff[i] <= 8'h0;
			histFill_ff <= 4'h0;
			badRun_ff   <= 2'h0;
			incons_ff   <= 1'b0;
			invalid_ff  <= 1'b0;
			modeMis_ff  <= 1'b0;
			chanMis_ff  <= 1'b0;
			rxLast_ff   <= 16'h0;
			farEndProtectLineFault_ff <= 1'b0;
		end
		else
		begin
			hist_ff     <= nxt_hist;
			histFill_ff <= nxt_histFill;
			badRun_ff   <= nxt_badRun;
			incons_ff   <= nxt_incons;
			invalid_ff  <= nxt_invalid;
			modeMis_ff  <= nxt_modeMis;
			chanMis_ff  <= nxt_chanMis;
			rxLast_ff   <= nxt_rxLast;
			farEndProtectLineFault_ff <= nxt_farEndProtectLineFault;
		end
	end

	// Clear beats a same-cycle onset: the operator asked for zero and gets zero.
	generate
		for (gi = 0; gi < `SABM_NUM_CNT; gi++)
		begin : g_cnt
			always_comb
			begin
				nxt_cnt[gi] = clrHit ? 32'h0 : cnt_ff[gi] + {31'h0, onset[gi]};
			end

			always_ff @(posedge clk)
			begin
				if (!rst_n)
					cnt_ff[gi] <= 32'h0;
				else
					cnt_ff[gi] <= nxt_cnt[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			condPrev_ff <= '0;
		else
			condPrev_ff <= cond;
	end

	// Revertive 1+1: leave port 0 on its fail, go back after a clean wait-to-restore.
	always_comb
	begin
		nxt_state  = state_ff;
		nxt_wtrCnt = wtrCnt_ff;
		unique case (state_ff)
			PS_NORMAL:
				if (signalFail[0] && !signalFail[1] && !ctrl_ff.lockout)
					nxt_state = PS_SWITCHED;
			PS_SWITCHED:
				if (ctrl_ff.lockout)
					nxt_state = PS_NORMAL;
				else if (!signalFail[0])
				begin
					nxt_state  = PS_WTR;
					nxt_wtrCnt = WTR_FRAMES;
				end
			PS_WTR:
				if (ctrl_ff.lockout)
					nxt_state = PS_NORMAL;
				else if (signalFail[0])
					nxt_state = PS_SWITCHED;
				else if (frameStb)
				begin
					if (wtrCnt_ff == 16'h0)
						nxt_state = PS_NORMAL;
					else
						nxt_wtrCnt = wtrCnt_ff - 16'h1;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_ff  <= PS_NORMAL;
			wtrCnt_ff <= 16'h0;
		end
		else
		begin
			state_ff  <= nxt_state;
			wtrCnt_ff <= nxt_wtrCnt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sqRecover;
		state_ff == PS_SWITCHED && !signalFail[0] && !ctrl_ff.lockout;
	endsequence

	chk_mode_flag: assert property (frameStb && rxBytes.k2[3:0] != {ctrl_ff.arch, ctrl_ff.mode}
		|=> modeMis_ff)
		else $error("mode mismatch not flagged");
	chk_chan_flag: assert property (frameStb && (rxBytes.k2[7:4] != ctrl_ff.txChan) |=> chanMis_ff)
		else $error("channel mismatch not flagged");
	chk_invalid_run: assert property (frameStb && badFrame && badRun_ff == 2'h2 |=> invalid_ff)
		else $error("invalid code not declared on third frame");
	chk_fepl_flag: assert property (frameStb && rxBytes.k1 == 8'hc0 |=> farEndProtectLineFault_ff)
		else $error("far end protection fault missed");
	chk_sf_count: assert property ($rose(signalFail[0]) && !clrHit |=> cnt_ff[4] == $past(cnt_ff[4]) + 32'h1)
		else $error("signal fail count did not step");
	chk_sd_count: assert property ($rose(signalDegrade[1]) && !clrHit |=> cnt_ff[7] == $past(cnt_ff[7]) + 32'h1)
		else $error("signal degrade count did not step");
	chk_lockout_hold: assert property (ctrl_ff.lockout |=> state_ff == PS_NORMAL)
		else $error("switch taken under lockout");
	chk_wtr_entry: assert property (sqRecover |=> state_ff == PS_WTR && statWord[8])
		else $error("wait to restore not reported");
	chk_clear_zero: assert property (clrHit |=> cnt_ff[0] == 32'h0 && cnt_ff[5] == 32'h0)
		else $error("counters not cleared");
	chk_sbf_onset: assert property ($rose(swByteFail) && !clrHit
		|=> cnt_ff[2] == $past(cnt_ff[2]) + 32'h1)
		else $error("switch byte failure onset not counted");
endmodule

//--- common/sabm_cfg.svh
// Purpose: Offsets, reset values, codes and counts of the APS byte monitor.
// Assumes: 32-bit APB, byte addresses, one word per register.
// Notes:   Definitions only.
`ifndef SABM_CFG_SVH
`define SABM_CFG_SVH
`define SABM_ADDR_CTRL     8'h00
`define SABM_ADDR_CLEAR    8'h04
`define SABM_ADDR_STAT     8'h08
`define SABM_ADDR_RXK      8'h0c
`define SABM_ADDR_CNT_LO   8'h10
`define SABM_ADDR_CNT_HI   8'h2c
`define SABM_CTRL_RST      9'h000
`define SABM_CLR_KEY       32'h00000059
`define SABM_HIST_LEN      12
`define SABM_HIST_FULL     4'hc
`define SABM_RUN_MAX       2'h3
`define SABM_RUN_DECLARE   2'h2
`define SABM_MAX_CHAN      4'h1
`define SABM_PROT_CHAN     4'h0
`define SABM_REQ_SF_LO     4'hc
`define SABM_REQ_SF_HI     4'hd
`define SABM_VALID_REQ     16'hfd07
`define SABM_WTR_FRAMES    16'h0400
`define SABM_NUM_CNT       8
`endif

//--- common/sabm_pkg.sv
// Purpose: Types shared by the APS byte monitor.
// Assumes: Constants live in sabm_cfg.svh.
// Notes:   Bit 1 of a SONET byte is the msb here.
package sabm_pkg;
	typedef struct packed
	{
		logic [7:0] k1;
		logic [7:0] k2;
	} sabm_rx_s;

	typedef struct packed
	{
		logic       lockout;
		logic [3:0] txChan;
		logic [2:0] mode;
		logic       arch;
	} sabm_ctrl_s;

	typedef enum logic [1:0]
	{
		PS_NORMAL,
		PS_SWITCHED,
		PS_WTR
	} sabm_prot_e;
endpackage

//--- bench/sabm_far_end.sv
// Purpose: Far-end APS channel model that sends one K1/K2 pair per frame.
// Assumes: A frame every 4 clocks, or every 10 while slow is high.
// Notes:   Between frames the bytes toggle every cycle, so a stale value never looks valid.
`timescale 1ns/10ps
module sabm_far_end
	import sabm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       slow,
	input  wire logic [3:0] req,
	input  wire logic [3:0] chan,
	input  wire logic [7:0] k2,
	output logic            frameStb,
	output sabm_rx_s        rxBytes
);
	logic [3:0] cnt;

	always_ff @(posedge clk)
	begin
		cnt      <= (!rst_n || cnt >= (slow ? 4'h9 : 4'h3)) ? 4'h0 : cnt + 4'h1;
		frameStb <= rst_n && cnt == 4'h0;
		rxBytes  <= !rst_n ? 16'h0 : (cnt == 4'h0) ? {req, chan, k2} : ~rxBytes;
	end
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the APS byte monitor.
// Assumes: APB slave answers with pready; frames come from the far-end model.
// Notes:   WTR_FRAMES is cut to 4 so the restore wait takes five frames.
`timescale 1ns/10ps
`include "sabm_cfg.svh"
module tb
	import sabm_pkg::*;
;
	typedef struct packed
	{
		logic [7:0] k1;
		logic [7:0] k2;
		logic [5:0] st;
	} sabm_row_s;

	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, frameStb, slow, err;
	logic [7:0]  paddr, k2;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  req, chan;
	logic [1:0]  sigFail, sigDeg;
	sabm_rx_s    rxBytes;
	int          nFail, cmpCount, cyc;
	// Channel count is two: the idle bytes before row 0 carry channel 0 while 1 is sent.
	int          expCnt [4] = '{1, 2, 2, 2};
	sabm_row_s   rows [13] = '{'{8'h01, 8'h10, 6'h00}, '{8'h01, 8'h15, 6'h01},
		'{8'h01, 8'h10, 6'h00}, '{8'h01, 8'h00, 6'h02}, '{8'h01, 8'h10, 6'h00},
		'{8'h31, 8'h10, 6'h24}, '{8'h01, 8'h10, 6'h00}, '{8'h02, 8'h10, 6'h24},
		'{8'h01, 8'h10, 6'h00}, '{8'hc0, 8'h10, 6'h08}, '{8'h01, 8'h10, 6'h00},
		'{8'hd0, 8'h10, 6'h08}, '{8'hc1, 8'h10, 6'h00}};

	sabm_aps_monitor #(.WTR_FRAMES(16'h0004)) sabm_aps_monitor_inst
	(
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frameStb(frameStb), .rxBytes(rxBytes),
		.signalFail(sigFail), .signalDegrade(sigDeg)
	);

	sabm_far_end sabm_far_end_inst
	(
		.clk(clk), .rst_n(rst_n), .slow(slow), .req(req), .chan(chan), .k2(k2),
		.frameStb(frameStb), .rxBytes(rxBytes)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			nFail++;
			endSim;
		end
	end

	task endSim;
		if (nFail == 0 && cmpCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			nFail++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// Ready, read data and error are all taken at the rising edge that ends the access.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task frames(input int n);
		repeat (n) @(negedge clk iff frameStb);
		repeat (2) @(posedge clk);
	endtask

	// New bytes are set just after a frame so no frame ever mixes old and new.
	task send(input logic [7:0] k1, input logic [7:0] b2, input int n);
		@(negedge clk iff frameStb);
		@(posedge clk);
		req  <= k1[7:4];
		chan <= k1[3:0];
		k2   <= b2;
		frames(n);
	endtask

	task stat(input logic [31:0] mask, input logic [31:0] exp);
		apb(1'b0, `SABM_ADDR_STAT, 32'h0);
		check(rd & mask, exp);
	endtask

	initial
	begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
		pwdata = 32'h0; slow = 1'b0; req = 4'h0; chan = 4'h0; k2 = 8'h0;
		sigFail = 2'h0; sigDeg = 2'h0; nFail = 0; cmpCount = 0; cyc = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		stat(32'hffffffff, 32'h0);
		apb(1'b1, `SABM_ADDR_CTRL, 32'h010);
		foreach (rows[i])
		begin
			send(rows[i].k1, rows[i].k2, 3);
			stat(32'h3f, 32'(rows[i].st));
		end
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, `SABM_ADDR_CNT_LO + 8'(4 * i), 32'h0);
			check(rd, 32'(expCnt[i]));
		end
		apb(1'b1, `SABM_ADDR_CLEAR, 32'h58);
		apb(1'b0, `SABM_ADDR_CNT_LO, 32'h0);
		check(rd, 32'h1);
		slow <= 1'b1;
		send(8'h31, 8'h10, 2);
		stat(32'h24, 32'h0);
		frames(1);
		stat(32'h24, 32'h24);
		for (int i = 0; i < 14; i++)
		begin
			@(negedge clk iff frameStb);
			@(posedge clk);
			req  <= 4'h0;
			chan <= {3'h0, i[0]};
		end
		frames(1);
		stat(32'h3f, 32'h14);
		send(8'h01, 8'h10, 3);
		stat(32'h14, 32'h0);
		slow <= 1'b0;
		for (int c = 0; c < 16; c++)
		begin
			send({4'(c), 4'h1}, 8'h10, 3);
			stat(32'h24, (c inside {[3:7], 9}) ? 32'h24 : 32'h0);
		end
		sigFail <= 2'b01;
		repeat (3) @(posedge clk);
		stat(32'h3fc0, 32'h4c0);
		sigFail <= 2'b00;
		repeat (3) @(posedge clk);
		stat(32'h180, 32'h100);
		frames(7);
		stat(32'h3fc0, 32'h0);
		apb(1'b1, `SABM_ADDR_CTRL, 32'h110);
		sigFail <= 2'b01;
		repeat (3) @(posedge clk);
		stat(32'h3fc0, 32'h600);
		sigFail <= 2'b00;
		sigDeg  <= 2'b10;
		apb(1'b1, `SABM_ADDR_CTRL, 32'h010);
		stat(32'h3fc0, 32'h2000);
		apb(1'b0, 8'h20, 32'h0);
		check(rd, 32'h2);
		apb(1'b0, `SABM_ADDR_CNT_HI, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, 8'h30, 32'h0);
		check({rd[30:0], err}, 32'h1);
		apb(1'b1, `SABM_ADDR_CLEAR, `SABM_CLR_KEY);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b0, `SABM_ADDR_CNT_LO + 8'(4 * i), 32'h0);
			check(rd, 32'h0);
		end
		endSim;
	end
endmodule
